// ===== design/ctw_defines.vh
`ifndef CTW_DEFINES_VH
`define CTW_DEFINES_VH

// ****************************************************************
// register byte offsets on the register bus
// ****************************************************************
`define CTW_OFF_IO_CONFIG   8'h00
`define CTW_OFF_TMODE       8'h04
`define CTW_OFF_TCTRL       8'h08
`define CTW_OFF_CNT_LOW     8'h0C
`define CTW_OFF_CNT_HIGH    8'h10
`define CTW_ADDR_MASK       8'hFC

// ****************************************************************
// register index codes used by the decoder
// ****************************************************************
`define CTW_IDX_IO_CONFIG   3'h0
`define CTW_IDX_TMODE       3'h1
`define CTW_IDX_TCTRL       3'h2
`define CTW_IDX_CNT_LOW     3'h3
`define CTW_IDX_CNT_HIGH    3'h4
`define CTW_IDX_NONE        3'h7

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CTW_IOC_CASCADE     6
`define CTW_IOC_WATCHDOG    7
`define CTW_TM_CT_LOW       2
`define CTW_TM_CT_HIGH      6
`define CTW_CT_RUN_LOW      0
`define CTW_CT_RUN_HIGH     1
`define CTW_CT_FLAG_LOW     2
`define CTW_CT_FLAG_HIGH    3
`define CTW_CT_PWR_DOWN     4
`define CTW_CT_WD_ACTIVE    5
`define CTW_RST_BYTE        8'h00
`define CTW_RST_CNT         16'h0000

// ****************************************************************
// timer modes, machine-cycle states, watchdog reset length
// ****************************************************************
`define CTW_MODE_13B        2'h0
`define CTW_MODE_16B        2'h1
`define CTW_MODE_RELOAD     2'h2
`define CTW_MODE_SPLIT      2'h3
`define CTW_PH_S1P1         4'h0
`define CTW_PH_S3P1         4'h4
`define CTW_PH_S5P1         4'h8
`define CTW_PH_S5P2         4'h9
`define CTW_PH_LAST         4'hB
`define CTW_WD_RST_MC       3'h5

// ****************************************************************
// bus responses
// ****************************************************************
`define CTW_RESP_OKAY       2'h0
`define CTW_RESP_SLVERR     2'h2

`endif

// ===== design/ctw_phase.v
`timescale 1ns/1ns
`include "ctw_defines.vh"

// ****************************************************************
// machine-cycle state sequencer, one state half per clock
// ****************************************************************
module ctw_phase
(
  // clock, reset, enable
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  // oscillator running
  input  wire       run,
  // state strobes
  output wire       s1p1,
  output wire       s3p1,
  output wire       s5p1,
  output wire       s5p2
);

  reg  [3:0] phase_ff;     // current state half, 0 = s1p1
  reg  [3:0] nxt_phase;    // next state half

  // ****************************************************************
  // twelve oscillator periods make one machine cycle
  // ****************************************************************
  always @*
  begin
    nxt_phase = phase_ff;
    if (run)
    begin
      // wrap after s6p2
      if (phase_ff == `CTW_PH_LAST)
        nxt_phase = `CTW_PH_S1P1;
      else
        nxt_phase = phase_ff + 4'h1;
    end
  end

  // a stopped oscillator freezes the sequence where it stands
  always @(posedge aclk)
  begin
    if (!aresetn)
      phase_ff <= `CTW_PH_S1P1;
    else if (ce)
      phase_ff <= nxt_phase;
  end

  // strobes fire only while the oscillator runs
  assign s1p1 = ce & run & (phase_ff == `CTW_PH_S1P1);
  assign s3p1 = ce & run & (phase_ff == `CTW_PH_S3P1);
  assign s5p1 = ce & run & (phase_ff == `CTW_PH_S5P1);
  assign s5p2 = ce & run & (phase_ff == `CTW_PH_S5P2);

endmodule

// ===== design/ctw_sync.v
`timescale 1ns/1ns

// ****************************************************************
// count pin synchroniser with sampled falling-edge detect
// ****************************************************************
module ctw_sync
(
  // clock, reset, enable
  input  wire       aclk,
  input  wire       aresetn,
  input  wire       ce,
  // asynchronous count pin
  input  wire       pin_async,
  // sample moment
  input  wire       sample_en,
  // one increment request
  output reg        fall_ff
);

  reg        meta_ff;      // first stage, read only by sync_ff
  reg        sync_ff;      // second stage, safe to use
  reg        last_ff;      // level seen at the previous sample

  // ****************************************************************
  // a 1 at one sample then a 0 at a later sample is one count
  // ****************************************************************
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
      fall_ff <= 1'b0;
    end
    else if (ce)
    begin
      meta_ff <= pin_async;
      sync_ff <= meta_ff;
      // pulses shorter than one sample period may be missed by design
      fall_ff <= sample_en & last_ff & ~sync_ff;
      if (sample_en)
        last_ff <= sync_ff;
    end
  end

endmodule

// ===== design/ctw_top.v
`timescale 1ns/1ns
`include "ctw_defines.vh"

// How it works
// - cascade bit chains both timers to 32 bits
// - cascade bit 6 starts and stops it
// - cascade cleared returns timers to mode register
// - internal 32-bit count steps at s3p1
// - low wrap carries without low overflow flag
// - 32-bit overflow sets high flag at s5p1, at once in power-down
// - external input sampled once per cycle at s5p2, every clock in power-down
// - count needs a 1 sample then 0
// - high overflow flag with watchdog forces reset
// - watchdog counts cycles or external pulses
// - reset starts next cycle, lasts five cycles
// - watchdog reset clears registers like hardware
// - power-down keeps external counting going
// - power-down overflow flags or forces reset
// - select bit picks internal or falling edges

module ctw_top
(
  // clock, reset, enable
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        ce,
  // write address channel
  input  wire [7:0]  awaddr,
  input  wire [2:0]  awprot,
  input  wire        awvalid,
  output wire        awready,
  // write data channel
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output wire        wready,
  // write response channel
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  // read address channel
  input  wire [7:0]  araddr,
  input  wire [2:0]  arprot,
  input  wire        arvalid,
  output wire        arready,
  // read data channel
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // count pins
  input  wire        external_count_input_low,
  input  wire        external_count_input_high,
  // overflow flags and core reset request
  output wire        low_timer_overflow_flag,
  output wire        high_timer_overflow_flag,
  output wire        cpu_reset_req
);

  // ****************************************************************
  // watchdog reset states
  // ****************************************************************
  localparam [1:0] WD_IDLE   = 2'h0;
  localparam [1:0] WD_PEND   = 2'h1;
  localparam [1:0] WD_ACTIVE = 2'h2;

  // ****************************************************************
  // shared functions
  // ****************************************************************
  // register decode, also used for reads and writes alike
  function [2:0] ctw_dec;
    input [7:0] addr;
    reg   [7:0] a;
    begin
      a = addr & `CTW_ADDR_MASK;
      case (a)
        `CTW_OFF_IO_CONFIG: ctw_dec = `CTW_IDX_IO_CONFIG;
        `CTW_OFF_TMODE:     ctw_dec = `CTW_IDX_TMODE;
        `CTW_OFF_TCTRL:     ctw_dec = `CTW_IDX_TCTRL;
        `CTW_OFF_CNT_LOW:   ctw_dec = `CTW_IDX_CNT_LOW;
        `CTW_OFF_CNT_HIGH:  ctw_dec = `CTW_IDX_CNT_HIGH;
        default:            ctw_dec = `CTW_IDX_NONE;
      endcase
    end
  endfunction

  // one step of a 16-bit timer in modes 0..2, msb is the overflow
  function [16:0] ctw_inc;
    input [1:0]  mode;
    input [15:0] v;
    reg   [13:0] t13;
    reg   [8:0]  t8;
    begin
      t13 = {1'b0, v[15:8], v[4:0]} + 14'h0001;
      t8  = {1'b0, v[7:0]} + 9'h001;
      case (mode)
        `CTW_MODE_13B:
          ctw_inc = {t13[13], t13[12:5], v[7:5], t13[4:0]};
        `CTW_MODE_RELOAD:
          // reload the low byte from the high byte on wrap
          ctw_inc = t8[8] ? {1'b1, v[15:8], v[15:8]}
                          : {1'b0, v[15:8], t8[7:0]};
        default:
          ctw_inc = {1'b0, v} + 17'h00001;
      endcase
    end
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  reg  [7:0]  io_config_ff;   // cascade and watchdog enables
  reg  [7:0]  tmode_ff;       // timer mode configuration
  reg         run_lo_ff;      // low timer run bit
  reg         run_hi_ff;      // high timer run bit
  reg         tf_lo_ff;       // low timer overflow flag
  reg         tf_hi_ff;       // high timer overflow flag
  reg         pwr_dn_ff;      // power-down bit
  reg  [15:0] cnt_lo_ff;      // low timer count
  reg  [15:0] cnt_hi_ff;      // high timer count
  reg         pend_lo_ff;     // low overflow waiting for s5p1
  reg         pend_hi_ff;     // high overflow waiting for s5p1
  reg  [1:0]  wd_state_ff;    // watchdog reset sequence
  reg  [2:0]  wd_cnt_ff;      // machine cycles of reset left
  reg         cpu_rst_ff;     // registered reset request
  reg         aw_held_ff;     // write address captured
  reg         w_held_ff;      // write data captured
  reg  [7:0]  awaddr_ff;      // captured write address
  reg  [31:0] wdata_ff;       // captured write data
  reg  [3:0]  wstrb_ff;       // captured byte strobes

  // ****************************************************************
  // timing strobes and count sources
  // ****************************************************************
  wire        s1p1;           // machine cycle start
  wire        s3p1;           // internal count moment
  wire        s5p1;           // flag set moment
  wire        s5p2;           // pin sample moment
  wire        fall_lo;        // counted edge on the low pin
  wire        fall_hi;        // counted edge on the high pin
  wire        wd_idle   = (wd_state_ff == WD_IDLE);
  wire        osc_stop  = pwr_dn_ff & wd_idle;  // oscillator stopped
  wire        cascade   = io_config_ff[`CTW_IOC_CASCADE];
  wire        wd_en     = io_config_ff[`CTW_IOC_WATCHDOG];
  wire [1:0]  mode_lo   = tmode_ff[1:0];
  wire [1:0]  mode_hi   = tmode_ff[5:4];
  // in power-down pins are taken every clock, asynchronous counting
  wire        sample_en = s5p2 | (ce & osc_stop);
  wire        flag_slot = s5p1 | (ce & osc_stop);
  // internal ticks stop with the oscillator; pins keep counting
  wire        tick_lo   = tmode_ff[`CTW_TM_CT_LOW]  ? fall_lo
                                                    : s3p1;
  wire        tick_hi   = tmode_ff[`CTW_TM_CT_HIGH] ? fall_hi
                                                    : s3p1;
  wire        wd_start  = (wd_state_ff == WD_PEND) & s1p1;
  wire        wd_hold   = wd_start | (wd_state_ff == WD_ACTIVE);

  // machine-cycle sequencer, runs again once a reset is pending
  ctw_phase u_phase
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .run     (~osc_stop),
    .s1p1    (s1p1),
    .s3p1    (s3p1),
    .s5p1    (s5p1),
    .s5p2    (s5p2)
  );

  // low count pin, sampled once a machine cycle, every clock in power-down
  ctw_sync u_sync_lo
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .pin_async (external_count_input_low),
    .sample_en (sample_en),
    .fall_ff   (fall_lo)
  );

  // high count pin
  ctw_sync u_sync_hi
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce),
    .pin_async (external_count_input_high),
    .sample_en (sample_en),
    .fall_ff   (fall_hi)
  );

  // ****************************************************************
  // register bus handshakes
  // ****************************************************************
  wire        do_write = aw_held_ff & w_held_ff & ~bvalid;
  wire [2:0]  widx     = ctw_dec(awaddr_ff);
  wire [2:0]  ridx     = ctw_dec(araddr);
  assign awready = ce & ~aw_held_ff & ~bvalid;
  assign wready  = ce & ~w_held_ff & ~bvalid;
  assign arready = ce & ~rvalid;

  // software writes decoded into strobes
  wire        wr_ioc  = do_write & (widx == `CTW_IDX_IO_CONFIG) & wstrb_ff[0];
  wire        wr_tm   = do_write & (widx == `CTW_IDX_TMODE) & wstrb_ff[0];
  wire        wr_ctl  = do_write & (widx == `CTW_IDX_TCTRL) & wstrb_ff[0];
  wire        wr_lo   = do_write & (widx == `CTW_IDX_CNT_LOW);
  wire        wr_hi   = do_write & (widx == `CTW_IDX_CNT_HIGH);
  wire        clr_lo  = wr_ctl & wdata_ff[`CTW_CT_FLAG_LOW];
  wire        clr_hi  = wr_ctl & wdata_ff[`CTW_CT_FLAG_HIGH];

  // ****************************************************************
  // counting
  // ****************************************************************
  reg  [15:0] nxt_cnt_lo;
  reg  [15:0] nxt_cnt_hi;
  reg         ovf_lo;         // low overflow this clock
  reg         ovf_hi;         // high overflow this clock
  reg  [32:0] sum32;
  reg  [16:0] step;
  reg  [8:0]  step8;

  always @*
  begin
    nxt_cnt_lo = cnt_lo_ff;
    nxt_cnt_hi = cnt_hi_ff;
    ovf_lo     = 1'b0;
    ovf_hi     = 1'b0;
    sum32      = {1'b0, cnt_hi_ff, cnt_lo_ff} + 33'h000000001;
    step       = 17'h00000;
    step8      = 9'h000;
    if (cascade)
    begin
      // one 32-bit counter, run bits play no part
      if (tick_lo)
      begin
        // low wrap carries straight on, low flag untouched
        nxt_cnt_lo = sum32[15:0];
        nxt_cnt_hi = sum32[31:16];
        ovf_hi     = sum32[32];
      end
    end
    else
    begin
      // individual timers as the mode register says
      if (mode_lo == `CTW_MODE_SPLIT)
      begin
        // low byte counts on its own source and run bit
        if (run_lo_ff & tick_lo)
        begin
          step8      = {1'b0, cnt_lo_ff[7:0]} + 9'h001;
          nxt_cnt_lo[7:0] = step8[7:0];
          ovf_lo     = step8[8];
        end
        // high byte is a plain timer owning the high flag
        if (run_hi_ff & s3p1)
        begin
          step8      = {1'b0, cnt_lo_ff[15:8]} + 9'h001;
          nxt_cnt_lo[15:8] = step8[7:0];
          ovf_hi     = step8[8];
        end
      end
      else if (run_lo_ff & tick_lo)
      begin
        step       = ctw_inc(mode_lo, cnt_lo_ff);
        nxt_cnt_lo = step[15:0];
        ovf_lo     = step[16];
      end
      // high timer: stopped in its own split mode, flagless when
      // the low timer has taken the high flag
      if ((mode_hi != `CTW_MODE_SPLIT) & tick_hi &
          (run_hi_ff | (mode_lo == `CTW_MODE_SPLIT)))
      begin
        step       = ctw_inc(mode_hi, cnt_hi_ff);
        nxt_cnt_hi = step[15:0];
        if (mode_lo != `CTW_MODE_SPLIT)
          ovf_hi   = step[16];
      end
    end
    // software writes take precedence over a count step
    if (wr_lo & wstrb_ff[0])
      nxt_cnt_lo[7:0] = wdata_ff[7:0];
    if (wr_lo & wstrb_ff[1])
      nxt_cnt_lo[15:8] = wdata_ff[15:8];
    if (wr_hi & wstrb_ff[0])
      nxt_cnt_hi[7:0] = wdata_ff[7:0];
    if (wr_hi & wstrb_ff[1])
      nxt_cnt_hi[15:8] = wdata_ff[15:8];
  end

  // flags rise at s5p1, or at once while power-down stops the states
  wire        set_lo = flag_slot & (pend_lo_ff | ovf_lo);
  wire        set_hi = flag_slot & (pend_hi_ff | ovf_hi);

  // ****************************************************************
  // configuration, counts and flags
  // ****************************************************************
  // a watchdog reset clears everything the way a hardware reset does
  always @(posedge aclk)
  begin
    if (!aresetn | (ce & wd_hold))
    begin
      io_config_ff <= `CTW_RST_BYTE;
      tmode_ff     <= `CTW_RST_BYTE;
      run_lo_ff    <= 1'b0;
      run_hi_ff    <= 1'b0;
      tf_lo_ff     <= 1'b0;
      tf_hi_ff     <= 1'b0;
      pwr_dn_ff    <= 1'b0;
      cnt_lo_ff    <= `CTW_RST_CNT;
      cnt_hi_ff    <= `CTW_RST_CNT;
      pend_lo_ff   <= 1'b0;
      pend_hi_ff   <= 1'b0;
    end
    else if (ce)
    begin
      // whole-byte writes can hit the watchdog bit by accident
      if (wr_ioc)
        io_config_ff <= wdata_ff[7:0];
      if (wr_tm)
        tmode_ff <= wdata_ff[7:0];
      if (wr_ctl)
      begin
        run_lo_ff <= wdata_ff[`CTW_CT_RUN_LOW];
        run_hi_ff <= wdata_ff[`CTW_CT_RUN_HIGH];
        pwr_dn_ff <= wdata_ff[`CTW_CT_PWR_DOWN];
      end
      cnt_lo_ff  <= nxt_cnt_lo;
      cnt_hi_ff  <= nxt_cnt_hi;
      pend_lo_ff <= ~flag_slot & (pend_lo_ff | ovf_lo);
      pend_hi_ff <= ~flag_slot & (pend_hi_ff | ovf_hi);
      // a new overflow beats a clear in the same clock
      tf_lo_ff   <= set_lo | (tf_lo_ff & ~clr_lo);
      tf_hi_ff   <= set_hi | (tf_hi_ff & ~clr_hi);
    end
  end

  // ****************************************************************
  // watchdog reset sequencer
  // ****************************************************************
  // flag rises at s5p1, so the next s1p1 opens the next machine cycle
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      wd_state_ff <= WD_IDLE;
      wd_cnt_ff   <= 3'h0;
      cpu_rst_ff  <= 1'b0;
    end
    else if (ce)
    begin
      case (wd_state_ff)
        WD_IDLE:
        begin
          // high flag in watchdog mode, also from power-down
          if (wd_en & tf_hi_ff)
            wd_state_ff <= WD_PEND;
        end
        WD_PEND:
        begin
          if (s1p1)
          begin
            wd_state_ff <= WD_ACTIVE;
            wd_cnt_ff   <= `CTW_WD_RST_MC;
            cpu_rst_ff  <= 1'b1;
          end
        end
        WD_ACTIVE:
        begin
          // release at the start of the sixth machine cycle
          if (s1p1)
          begin
            if (wd_cnt_ff == 3'h1)
            begin
              wd_state_ff <= WD_IDLE;
              cpu_rst_ff  <= 1'b0;
            end
            wd_cnt_ff <= wd_cnt_ff - 3'h1;
          end
        end
        default:
        begin
          wd_state_ff <= WD_IDLE;
          cpu_rst_ff  <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // register bus slave
  // ****************************************************************
  // address and data are taken in either order, answered together
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= 8'h00;
      wdata_ff   <= 32'h00000000;
      wstrb_ff   <= 4'h0;
      bvalid     <= 1'b0;
      bresp      <= `CTW_RESP_OKAY;
      rvalid     <= 1'b0;
      rresp      <= `CTW_RESP_OKAY;
      rdata      <= 32'h00000000;
    end
    else if (ce)
    begin
      // capture address
      if (awvalid & awready)
      begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= awaddr;
      end
      // capture data
      if (wvalid & wready)
      begin
        w_held_ff <= 1'b1;
        wdata_ff  <= wdata;
        wstrb_ff  <= wstrb;
      end
      // answer once both halves are in
      if (do_write)
      begin
        aw_held_ff <= 1'b0;
        w_held_ff  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= (widx == `CTW_IDX_NONE) ? `CTW_RESP_SLVERR
                                              : `CTW_RESP_OKAY;
      end
      else if (bready)
        bvalid <= 1'b0;
      // reads answer one clock after the address is taken
      if (arvalid & arready)
      begin
        rvalid <= 1'b1;
        rresp  <= `CTW_RESP_OKAY;
        case (ridx)
          `CTW_IDX_IO_CONFIG: rdata <= {24'h000000, io_config_ff};
          `CTW_IDX_TMODE:     rdata <= {24'h000000, tmode_ff};
          `CTW_IDX_TCTRL:
            rdata <= {26'h0000000, ~wd_idle, pwr_dn_ff, tf_hi_ff,
                      tf_lo_ff, run_hi_ff, run_lo_ff};
          `CTW_IDX_CNT_LOW:   rdata <= {16'h0000, cnt_lo_ff};
          `CTW_IDX_CNT_HIGH:  rdata <= {16'h0000, cnt_hi_ff};
          default:
          begin
            rdata <= 32'h00000000;
            rresp <= `CTW_RESP_SLVERR;
          end
        endcase
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign low_timer_overflow_flag  = tf_lo_ff;
  assign high_timer_overflow_flag = tf_hi_ff;
  assign cpu_reset_req            = cpu_rst_ff;

endmodule

// ===== testbench/ctw_assertions.sv
`timescale 1ns/1ns
module ctw_assertions
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // bus handshakes
  input wire        awready,
  input wire        wready,
  input wire [1:0]  bresp,
  input wire        bvalid,
  input wire        bready,
  input wire        arvalid,
  input wire        arready,
  input wire [31:0] rdata,
  input wire        rvalid,
  input wire        rready,
  // flags and reset request
  input wire        low_timer_overflow_flag,
  input wire        high_timer_overflow_flag,
  input wire        cpu_reset_req
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // reset length counter, too long for a repetition
  // ****************
  reg [6:0] len_ff;
  always @(posedge aclk)
    if (!aresetn || !cpu_reset_req)
      len_ff <= 7'h00;
    else
      len_ff <= len_ff + 7'h01;
  a_rst_len: assert property ($fell(cpu_reset_req) |->
    len_ff == 7'h3C)
    else $error("watchdog reset not 60 clocks");
  a_rst_cap: assert property (cpu_reset_req |-> len_ff < 7'h3C)
    else $error("watchdog reset too long");
  // a registered reset request opens the watchdog sequence
  sequence s_wd_fire;
    $rose(cpu_reset_req);
  endsequence
  a_rst_cause: assert property (s_wd_fire |->
    $past(high_timer_overflow_flag))
    else $error("reset without high overflow");
  a_rst_clears: assert property (cpu_reset_req |->
    !high_timer_overflow_flag && !low_timer_overflow_flag)
    else $error("flags alive during reset");
  a_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  a_rd_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_bus_block: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
endmodule
bind ctw_top ctw_assertions u_chk (.*);

// ===== testbench/ctw_pulse_src.sv
`timescale 1ns/1ns
// ****************
// far-side event source: 24 clocks per level, 48 per period
// ****************
module ctw_pulse_src
(
  // clock and gate
  input  wire aclk,
  input  wire en,
  // count pin, idles high
  output reg  pin
);
  reg [4:0] cnt_ff; // clocks spent in current level
  // toggle slow enough for two sample points per level
  always @(posedge aclk)
    if (!en)
    begin
      pin <= 1'b1;
      cnt_ff <= 5'h00;
    end
    else if (cnt_ff == 5'h17)
    begin
      pin <= ~pin;
      cnt_ff <= 5'h00;
    end
    else
      cnt_ff <= cnt_ff + 5'h01;
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
`include "ctw_defines.vh"
module tb_top;
  // bench-driven inputs, constants and outputs
  reg         aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, src_en;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd_data;
  wire        ce = 1'b1, external_count_input_high = 1'b1;
  wire [2:0]  awprot = 3'h0, arprot = 3'h0;
  wire [3:0]  wstrb = 4'hF;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire        awready, wready, bvalid, arready, rvalid, cpu_reset_req;
  wire        external_count_input_low, low_timer_overflow_flag;
  wire        high_timer_overflow_flag;
  integer     num_errors = 0, checked = 0, cyc = 0, falls = 0;
  ctw_top dut (.*);
  ctw_pulse_src u_src (.aclk(aclk), .en(src_en),
                       .pin(external_count_input_low));
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // falls seen on the pin give the expected event count
  always @(negedge external_count_input_low) falls = falls + 1;
  // hang guard
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      num_errors = num_errors + 1;
      report_and_stop;
    end
  end
  task report_and_stop;
  begin
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  task chk(input string n, input [31:0] e, input [31:0] g);
  begin
    checked = checked + 1;
    if (e !== g)
    begin
      num_errors = num_errors + 1;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  end
  endtask
  // write: address and data offered together, each dropped when taken
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge aclk);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do
    begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while ((awvalid && !awready) || (wvalid && !wready));
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd_data = rdata;
    rready <= 1'b0;
  end
  endtask
  task cyc_wait(input integer n);
    repeat (n) @(posedge aclk);
  endtask
  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, src_en} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    cyc_wait(3);
    aresetn <= 1'b1;
    rd(`CTW_OFF_IO_CONFIG);
    chk("io_config rst", 32'h0, rd_data);
    rd(8'h40);
    chk("unmapped resp", `CTW_RESP_SLVERR, rresp);
    wr(8'h40, 32'h0);
    chk("unmapped wr resp", `CTW_RESP_SLVERR, bresp);
    wr(`CTW_OFF_CNT_LOW, 32'hFFF0);
    wr(`CTW_OFF_CNT_HIGH, 32'hFFFF);
    wr(`CTW_OFF_IO_CONFIG, 32'h40);
    for (int i = 0; i < 300 && !high_timer_overflow_flag; i++) @(posedge aclk);
    chk("high flag", 1'b1, high_timer_overflow_flag);
    chk("low flag", 1'b0, low_timer_overflow_flag);
    wr(`CTW_OFF_IO_CONFIG, 32'h0);
    wr(`CTW_OFF_TCTRL, 32'h0C);
    wr(`CTW_OFF_CNT_LOW, 32'hFFFF);
    wr(`CTW_OFF_CNT_HIGH, 32'h0001);
    wr(`CTW_OFF_IO_CONFIG, 32'h40);
    cyc_wait(30);
    wr(`CTW_OFF_IO_CONFIG, 32'h0);
    rd(`CTW_OFF_CNT_HIGH);
    chk("carry", 32'h2, rd_data);
    cyc_wait(48);
    rd(`CTW_OFF_CNT_HIGH);
    chk("stopped", 32'h2, rd_data);
    wr(`CTW_OFF_TMODE, 32'h04);
    wr(`CTW_OFF_CNT_LOW, 32'h0);
    wr(`CTW_OFF_CNT_HIGH, 32'h0);
    wr(`CTW_OFF_IO_CONFIG, 32'h40);
    falls = 0;
    src_en <= 1'b1;
    cyc_wait(250);
    src_en <= 1'b0;
    cyc_wait(48);
    rd(`CTW_OFF_CNT_LOW);
    chk("events", falls, rd_data);
    wr(`CTW_OFF_TMODE, 32'h0);
    wr(`CTW_OFF_CNT_LOW, 32'hFFFE);
    wr(`CTW_OFF_CNT_HIGH, 32'hFFFF);
    wr(`CTW_OFF_IO_CONFIG, 32'hC0);
    for (int i = 0; i < 100 && !cpu_reset_req; i++) @(posedge aclk);
    chk("wd reset", 1'b1, cpu_reset_req);
    for (int i = 0; i < 100 && cpu_reset_req; i++) @(posedge aclk);
    rd(`CTW_OFF_IO_CONFIG);
    chk("io_config wd", 32'h0, rd_data);
    rd(`CTW_OFF_CNT_HIGH);
    chk("count wd", 32'h0, rd_data);
    // oscillator stopped: pin falls still count, flag rises at once
    wr(`CTW_OFF_TMODE, 32'h05);
    wr(`CTW_OFF_CNT_LOW, 32'hFFFE);
    wr(`CTW_OFF_TCTRL, 32'h11);
    src_en <= 1'b1;
    cyc_wait(100);
    chk("sleep low flag", 1'b1, low_timer_overflow_flag);
    chk("sleep high flag", 1'b0, high_timer_overflow_flag);
    report_and_stop;
  end
endmodule
